// ---- hdl/pll_holdover_defs.svh ----
// Offsets, field positions and reset values of the holdover control and status bank.
// Assumes inclusion by bare name from the register bank module.
`ifndef PLL_HOLDOVER_DEFS_SVH
`define PLL_HOLDOVER_DEFS_SVH
`define HOLDOVER_CONTROL_ADDR 8'h1d
`define STATUS_READBACK_ADDR 8'h1f
`define CTRL_HOLD_EN_A_BIT 0
`define CTRL_EXT_HOLD_BIT 1
`define CTRL_HOLD_EN_B_BIT 2
`define CTRL_LOCK_CMP_EN_BIT 3
`define CTRL_STATUS_DIS_BIT 4
`define CTRL_RESET_VALUE 8'h00
`define CTRL_WRITE_MASK 8'h1f
`define STAT_LOCK_BIT 0
`define STAT_PRI_THR_BIT 1
`define STAT_SEC_THR_BIT 2
`define STAT_VCO_THR_BIT 3
`define STAT_SEC_SEL_BIT 4
`define STAT_HOLD_ACT_BIT 5
`define STAT_CAL_DONE_BIT 6
`endif

// ---- hdl/pll_holdover_pkg.sv ----
// Types used by the holdover register bank.
// Assumes the defs header is on the include path.
package pll_holdover_pkg;
  typedef struct packed {
    logic cal_done;
    logic holdover_active;
    logic secondary_selected;
    logic vco_above;
    logic secondary_above;
    logic primary_above;
    logic digital_lock_indication;
  } pll_status_t;
  typedef struct packed {
    logic lock_cmp_en;
    logic ext_hold;
    logic holdover_enabled;
  } hold_ctrl_t;
  typedef enum logic [1:0] {IDLE, WRITE, READ} bus_state_t;
endpackage : pll_holdover_pkg

// ---- hdl/pin_sync.sv ----
// Two-stage synchroniser for a group of asynchronous status pins.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 9
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule : pin_sync

// ---- hdl/pll_holdover_status_regs.sv ----
// Holdover control register and PLL status readback register.
// Assumes a byte-wide register port on core_clk_i; status inputs come from pins.
`timescale 1ns/1ps
`include "pll_holdover_defs.svh"
module pll_holdover_status_regs
  import pll_holdover_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic lock_indicator_pin_i,
  input wire logic hold_request_n_i,
  input wire logic cal_done_i,
  input wire logic holdover_state_i,
  input wire logic secondary_selected_i,
  input wire logic vco_above_i,
  input wire logic secondary_above_i,
  input wire logic primary_above_i,
  input wire logic digital_lock_indication_i,
  output logic lock_cmp_enable_o,
  output logic auto_lock_seen_o,
  output logic holdover_enabled_o,
  output logic auto_holdover_mode_o,
  output logic external_hold_o,
  output logic reference_monitor_pin_o
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [8:0] pins_async;
  logic [8:0] pins;
  pll_status_t status;
  logic lock_pin;
  logic hold_req_n;
  assign pins_async = {lock_indicator_pin_i, hold_request_n_i, cal_done_i, holdover_state_i,
                       secondary_selected_i, vco_above_i, secondary_above_i,
                       primary_above_i, digital_lock_indication_i};
  pin_sync #(.WIDTH(9)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(pins_async),
    .sync_o(pins)
  );
  assign lock_pin = pins[8];
  assign hold_req_n = pins[7];
  assign status = pll_status_t'(pins[6:0]);

  // ****************************************
  // Register port
  // ****************************************
  logic [7:0] ctrl;
  hold_ctrl_t hc;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
    hit = (a == ref_addr);
  endfunction : hit

  // Decoded strobes; wr_ctrl feeds the control register, the others serve only the checks
  logic wr_ctrl;
  logic wr_status;
  logic rd_ctrl;
  logic rd_status;
  logic rd_other;
  logic status_seen;
  assign wr_ctrl = reg_wr_i & hit(reg_addr_i, `HOLDOVER_CONTROL_ADDR);
  assign wr_status = reg_wr_i & hit(reg_addr_i, `STATUS_READBACK_ADDR);
  assign rd_ctrl = reg_rd_i & hit(reg_addr_i, `HOLDOVER_CONTROL_ADDR);
  assign rd_status = reg_rd_i & hit(reg_addr_i, `STATUS_READBACK_ADDR);
  assign rd_other = reg_rd_i & ~rd_ctrl & ~rd_status;
  assign status_seen = rd_status & ~ctrl[`CTRL_STATUS_DIS_BIT];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RESET_VALUE;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata_i & `CTRL_WRITE_MASK;
    end
  end

  // Writes to the readback address fall through here untouched
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i && hit(reg_addr_i, `HOLDOVER_CONTROL_ADDR)) begin
        reg_rdata_o <= ctrl;
      end else if (reg_rd_i && hit(reg_addr_i, `STATUS_READBACK_ADDR)) begin
        // Status disable bit freezes readback at zero
        reg_rdata_o <= ctrl[`CTRL_STATUS_DIS_BIT] ? 8'h00 : {1'b0, status};
      end else if (reg_rd_i) begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // ****************************************
  // Holdover control
  // ****************************************
  assign hc.lock_cmp_en = ctrl[`CTRL_LOCK_CMP_EN_BIT];
  assign hc.ext_hold = ctrl[`CTRL_EXT_HOLD_BIT];
  assign hc.holdover_enabled = ctrl[`CTRL_HOLD_EN_B_BIT] & ctrl[`CTRL_HOLD_EN_A_BIT];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_cmp_enable_o <= 1'b0;
      auto_lock_seen_o <= 1'b1;
      holdover_enabled_o <= 1'b0;
      auto_holdover_mode_o <= 1'b0;
      external_hold_o <= 1'b0;
      reference_monitor_pin_o <= 1'b0;
    end else begin
      lock_cmp_enable_o <= hc.lock_cmp_en;
      // Disabled comparator reads as locked so auto holdover is never blocked
      auto_lock_seen_o <= hc.lock_cmp_en ? lock_pin : 1'b1;
      holdover_enabled_o <= hc.holdover_enabled;
      auto_holdover_mode_o <= hc.holdover_enabled & ~hc.ext_hold;
      external_hold_o <= hc.holdover_enabled & hc.ext_hold & ~hold_req_n;
      reference_monitor_pin_o <= hc.lock_cmp_en & lock_pin;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_cmp_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ##1 lock_cmp_enable_o == $past(ctrl[`CTRL_LOCK_CMP_EN_BIT]))
    else $error("comparator enable wrong");
  chk_cmp_off_high: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !ctrl[`CTRL_LOCK_CMP_EN_BIT] |=> auto_lock_seen_o)
    else $error("lock seen not high");
  chk_cmp_on_pin: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ctrl[`CTRL_LOCK_CMP_EN_BIT] |=> auto_lock_seen_o == $past(lock_pin))
    else $error("lock seen mismatch");
  chk_hold_enable: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(ctrl[`CTRL_HOLD_EN_A_BIT] && ctrl[`CTRL_HOLD_EN_B_BIT]) |=>
      !holdover_enabled_o && !auto_holdover_mode_o && !external_hold_o)
    else $error("holdover enabled wrongly");
  chk_hold_on: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ctrl[`CTRL_HOLD_EN_A_BIT] && ctrl[`CTRL_HOLD_EN_B_BIT]) |=> holdover_enabled_o)
    else $error("holdover not enabled");
  chk_ext_mode: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ctrl[`CTRL_EXT_HOLD_BIT] |=> !auto_holdover_mode_o)
    else $error("auto mode in external");
  chk_auto_mode: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ctrl[2:0] == 3'b101) |=> auto_holdover_mode_o && !external_hold_o)
    else $error("auto mode missing");
  chk_ext_follow: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ctrl[2:0] == 3'b111) |=> external_hold_o == !$past(hold_req_n))
    else $error("external hold mismatch");

  // ****************************************
  // Checks: readback and monitor pin
  // ****************************************
  chk_read_live: assert property (@(posedge core_clk_i) disable iff (rst_i)
    status_seen |=> reg_rdata_o == {1'b0, $past(pins[6:0])})
    else $error("status readback wrong");
  chk_cal_bit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    status_seen |=> reg_rdata_o[`STAT_CAL_DONE_BIT] == $past(pins[6]))
    else $error("calibration bit wrong");
  chk_hold_bit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    status_seen |=> reg_rdata_o[`STAT_HOLD_ACT_BIT] == $past(pins[5]))
    else $error("holdover active bit wrong");
  chk_ref_select: assert property (@(posedge core_clk_i) disable iff (rst_i)
    status_seen |=> reg_rdata_o[`STAT_SEC_SEL_BIT] == $past(pins[4]))
    else $error("reference select bit wrong");
  chk_vco_bit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    status_seen |=> reg_rdata_o[`STAT_VCO_THR_BIT] == $past(pins[3]))
    else $error("vco threshold bit wrong");
  chk_sec_bit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    status_seen |=> reg_rdata_o[`STAT_SEC_THR_BIT] == $past(pins[2]))
    else $error("secondary threshold bit wrong");
  chk_pri_bit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    status_seen |=> reg_rdata_o[`STAT_PRI_THR_BIT] == $past(pins[1]))
    else $error("primary threshold bit wrong");
  chk_lock_bit: assert property (@(posedge core_clk_i) disable iff (rst_i)
    status_seen |=> reg_rdata_o[`STAT_LOCK_BIT] == $past(pins[0]))
    else $error("lock bit wrong");
  chk_status_off: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rd_status && ctrl[`CTRL_STATUS_DIS_BIT]) |=> reg_rdata_o == 8'h00)
    else $error("disabled readback not zero");
  chk_unmapped_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    rd_other |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_ro_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
    wr_status |=> $stable(ctrl))
    else $error("readback write took");
  chk_monitor: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ##1 reference_monitor_pin_o == $past(ctrl[`CTRL_LOCK_CMP_EN_BIT] & lock_pin))
    else $error("monitor wrong");

  // ****************************************
  // Cover points
  // ****************************************
  cov_auto: cover property (@(posedge core_clk_i) disable iff (rst_i) auto_holdover_mode_o);
  cov_ext: cover property (@(posedge core_clk_i) disable iff (rst_i) external_hold_o);
  cov_read: cover property (@(posedge core_clk_i) disable iff (rst_i) status_seen);
  cov_status_off: cover property (@(posedge core_clk_i) disable iff (rst_i)
    rd_status && ctrl[`CTRL_STATUS_DIS_BIT]);
  cov_cmp_low: cover property (@(posedge core_clk_i) disable iff (rst_i)
    lock_cmp_enable_o && !auto_lock_seen_o);
endmodule : pll_holdover_status_regs

// ---- tb/host_port_model.sv ----
// Host model driving the byte register port with one-cycle strobes.
// Assumes the bench calls wr and rd by hierarchical name.
`timescale 1ns/1ps
module host_port_model (
  input wire logic core_clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    addr_o <= a;
    wdata_o <= v;
    wr_o <= 1'b1;
    @(posedge core_clk_i);
    wr_o <= 1'b0;
    // Released bus shows inverse values, not the last ones
    addr_o <= ~a;
    wdata_o <= ~v;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    int n;
    @(posedge core_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge core_clk_i);
    rd_o <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (rvalid_i !== 1'b1 && n < 8);
    // Missing answer reads as unknown so the compare trips
    v = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
    addr_o <= ~a;
  endtask : rd
endmodule : host_port_model

// ---- tb/pll_holdover_status_regs_test.sv ----
// Bench for the holdover control and status register bank.
// Assumes the host model drives the register port; status pins are levels.
`timescale 1ns/1ps
module pll_holdover_status_regs_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic lp = 1'b0;
  logic hn = 1'b1;
  logic [6:0] st = 7'h00;
  logic [7:0] addr, wdata, rdata, d, outs;
  logic wr, rd, rvalid, cen, seen, hen, amode, ext, rmon;
  int n_mismatch = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  assign outs = {2'h0, rmon, cen, seen, hen, amode, ext};
  host_port_model host (.core_clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  pll_holdover_status_regs dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .lock_indicator_pin_i(lp), .hold_request_n_i(hn),
    .cal_done_i(st[6]), .holdover_state_i(st[5]), .secondary_selected_i(st[4]),
    .vco_above_i(st[3]), .secondary_above_i(st[2]), .primary_above_i(st[1]),
    .digital_lock_indication_i(st[0]), .lock_cmp_enable_o(cen),
    .auto_lock_seen_o(seen), .holdover_enabled_o(hen), .auto_holdover_mode_o(amode),
    .external_hold_o(ext), .reference_monitor_pin_o(rmon));
  // ****************************************
  // Scenarios
  // ****************************************
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  // Covers two sync stages plus the output register
  task settle;
    repeat (4) @(posedge clk);
    #1;
  endtask : settle
  task ctl(input logic [7:0] v, input logic h, input logic l, input logic [7:0] e);
    @(posedge clk);
    hn <= h;
    lp <= l;
    host.wr(8'h1d, v);
    settle;
    chk(outs, e);
  endtask : ctl
  task test_status;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      st <= 7'h01 << i;
      settle;
      host.rd(8'h1f, d);
      chk(d, 8'h01 << i);
    end
  endtask : test_status
  task test_refused;
    @(posedge clk);
    st <= 7'h55;
    host.wr(8'h1f, 8'h00);
    settle;
    host.rd(8'h1f, d);
    chk(d, 8'h55);
    host.wr(8'h1d, 8'hff);
    host.rd(8'h1d, d);
    chk(d, 8'h1f);
    host.rd(8'h1f, d);
    chk(d, 8'h00);
    host.rd(8'h40, d);
    chk(d, 8'h00);
  endtask : test_refused
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial begin
    #200000;
    n_mismatch++;
    test_done;
  end
  task test_reset;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle;
    chk(outs, 8'h08);
    host.rd(8'h1d, d);
    chk(d, 8'h00);
  endtask : test_reset
  task test_control;
    ctl(8'h05, 1'b1, 1'b0, 8'h0e);
    ctl(8'h04, 1'b1, 1'b0, 8'h08);
    ctl(8'h01, 1'b0, 1'b0, 8'h08);
    ctl(8'h07, 1'b1, 1'b0, 8'h0c);
    ctl(8'h07, 1'b0, 1'b0, 8'h0d);
    ctl(8'h08, 1'b1, 1'b0, 8'h10);
    ctl(8'h08, 1'b1, 1'b1, 8'h38);
    ctl(8'h0d, 1'b1, 1'b0, 8'h16);
    ctl(8'h00, 1'b1, 1'b0, 8'h08);
  endtask : test_control
  initial begin
    test_reset;
    test_control;
    test_status;
    test_refused;
    test_done;
  end
endmodule : pll_holdover_status_regs_test
